// ### rtl/acs_status.sv
// Converter status register with its serial read path and ready pin
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Read-only 8-bit status at index 0x00, reset value 0x80.
// - With append enabled, status byte follows the 24-bit result on data reads.
// - Ready flag drives the serial-out pin while selected and not reading.
// - Ready flag drops to 0 when a new result lands; 1 means waiting.
// - During calibration, ready flag drops when the calibration result is stored.
// - A read of the data register returns the ready flag to 1.
// - Overrange clamps result to all ones, underrange to zeros; range flag set.
// - Range flag changes only on result writes; clears on first clean result.
// - Write-check flag sets on a CRC mismatch during a host register write.
// - Reading the status register clears the write-check flag.
// - With integrity check on, any change from the reference sets integrity flag.
// - Integrity flag clears only when the integrity check is switched off.
// - Bits 3 and 2 read as zero.
// - Bits 1:0 give the channel of the result held, not the current one.
// - A mode register write sets the ready flag.
module acs_status #(
  parameter int CHK_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic result_wr,
  input wire logic [acs_pkg::ACS_DATA_W-1:0] result_raw,
  input wire logic result_over,
  input wire logic result_under,
  input wire logic [acs_pkg::ACS_CHAN_W-1:0] result_chan,
  input wire logic cal_done,
  input wire logic mode_wr,
  input wire logic crc_wr_err,
  input wire logic data_stat_en,
  input wire logic reg_check_en,
  input wire logic [CHK_W-1:0] reg_sum,
  output logic [7:0] status,
  output logic [acs_pkg::ACS_DATA_W-1:0] result_data
);
  import acs_pkg::*;

  typedef struct packed {
    logic rdy;
    logic range_err;
    logic wcrc_err;
    logic integ_err;
    logic [ACS_CHAN_W-1:0] chan;
    logic [ACS_DATA_W-1:0] data;
    logic [CHK_W-1:0] ref_sum;
    logic chk_en_d;
    logic stat_rd_d;
    logic data_rd_d;
    logic oe;
    logic [31:0] shadow;
    logic append;
    logic [7:0] stat;
  } acs_core_s;

  acs_core_s st_r;
  acs_core_s st_nxt;

  logic link_reading;
  logic link_bit;
  logic stat_lvl;
  logic data_lvl;
  logic [2:0] sync_in;
  logic [2:0] sync_q;
  logic stat_rd_ev;
  logic data_rd_ev;

  generate
    if (CHK_W < 1) begin : g_bad_chk
      $error("acs_status CHK_W must be at least one");
    end
  endgenerate

  // Assemble the status byte; reserved bits forced low
  function automatic logic [7:0] pack_status(input acs_core_s s);
    logic [7:0] v;
    v = 8'h00;
    v[ACS_RDY_BIT] = s.rdy;
    v[ACS_RANGE_BIT] = s.range_err;
    v[ACS_WCRC_BIT] = s.wcrc_err;
    v[ACS_INTEG_BIT] = s.integ_err;
    v[ACS_CHAN_LSB +: ACS_CHAN_W] = s.chan;
    return v;
  endfunction

  // Clamp a raw result to the full-scale codes on a range fault
  function automatic logic [ACS_DATA_W-1:0] clamp(input logic [ACS_DATA_W-1:0] raw,
                                                  input logic over, input logic under);
    logic [ACS_DATA_W-1:0] v;
    v = raw;
    if (over) begin
      v = ACS_CLAMP_HI;
    end else if (under) begin
      v = ACS_CLAMP_LO;
    end
    return v;
  endfunction

  acs_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .snap_word(st_r.shadow),
    .snap_append(st_r.append),
    .reading(link_reading),
    .tx_bit(link_bit),
    .stat_rd_lvl(stat_lvl),
    .data_rd_lvl(data_lvl)
  );

  // Frame-long levels from the link cross as levels and are edge-detected here
  assign sync_in = {stat_lvl, data_lvl, ~cs_n};

  acs_sync #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sync_in),
    .sync_out(sync_q)
  );

  assign stat_rd_ev = sync_q[2] & ~st_r.stat_rd_d;
  assign data_rd_ev = sync_q[1] & ~st_r.data_rd_d;

  always_comb begin
    st_nxt = st_r;
    st_nxt.stat_rd_d = sync_q[2];
    st_nxt.data_rd_d = sync_q[1];
    st_nxt.oe = sync_q[0];
    st_nxt.chk_en_d = reg_check_en;

    // Ready flag: a landing result beats a data read or mode write in the same cycle
    if (result_wr || cal_done) begin
      st_nxt.rdy = 1'b0;
    end else if (data_rd_ev || mode_wr) begin
      st_nxt.rdy = 1'b1;
    end

    // Result capture with range check and source channel
    if (result_wr) begin
      st_nxt.data = clamp(result_raw, result_over, result_under);
      st_nxt.range_err = result_over | result_under;
      st_nxt.chan = result_chan;
    end

    // Write-check flag: a new mismatch wins over the clearing read
    if (crc_wr_err) begin
      st_nxt.wcrc_err = 1'b1;
    end else if (stat_rd_ev) begin
      st_nxt.wcrc_err = 1'b0;
    end

    // Integrity: reference taken when the check turns on, compared every cycle after
    if (!reg_check_en) begin
      st_nxt.integ_err = 1'b0;
    end else if (!st_r.chk_en_d) begin
      st_nxt.ref_sum = reg_sum;
    end else if (reg_sum != st_r.ref_sum) begin
      st_nxt.integ_err = 1'b1;
    end

    // Snapshot frozen while selected so the link domain reads a still word
    if (!sync_q[0]) begin
      st_nxt.shadow = {st_r.data, pack_status(st_r)};
      st_nxt.append = data_stat_en;
    end

    // Status byte held in its own flop so the output port carries no logic
    st_nxt.stat = pack_status(st_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.rdy <= ACS_STATUS_RST[ACS_RDY_BIT];
      st_r.stat <= ACS_STATUS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.stat;
  assign result_data = st_r.data;
  assign sdo_oe = st_r.oe;
  // Ready flag shows on the pin unless a read is shifting out
  assign sdo = link_reading ? link_bit : st_r.rdy;
endmodule
`default_nettype wire

// ### rtl/acs_pkg.sv
// Shared constants and types for the converter status register block
package acs_pkg;

  // Register indices carried in the target_register_index field of the command byte
  localparam logic [5:0] ACS_STATUS_IDX = 6'h00;
  localparam logic [5:0] ACS_DATA_IDX = 6'h04;

  // conversion_status layout and reset value
  localparam logic [7:0] ACS_STATUS_RST = 8'h80;
  localparam int ACS_RDY_BIT = 7;
  localparam int ACS_RANGE_BIT = 6;
  localparam int ACS_WCRC_BIT = 5;
  localparam int ACS_INTEG_BIT = 4;
  localparam int ACS_CHAN_LSB = 0;
  localparam int ACS_CHAN_W = 2;

  // command_byte_register fields
  localparam int ACS_CMD_WEN_BIT = 7;
  localparam int ACS_CMD_RW_BIT = 6;
  localparam int ACS_CMD_BITS = 8;

  // Result word and clamp codes
  localparam int ACS_DATA_W = 24;
  localparam logic [23:0] ACS_CLAMP_HI = 24'hffffff;
  localparam logic [23:0] ACS_CLAMP_LO = 24'h000000;

  // Serial lengths of the two reads this block serves
  localparam logic [5:0] ACS_LEN_STATUS = 6'h08;
  localparam logic [5:0] ACS_LEN_DATA = 6'h18;
  localparam logic [5:0] ACS_LEN_DATA_APP = 6'h20;

  // Phases of a serial frame
  typedef enum logic [2:0] {
    ACS_PH_CMD = 3'b001,
    ACS_PH_SHIFT = 3'b010,
    ACS_PH_DONE = 3'b100
  } acs_phase_e;

endpackage

// ### rtl/acs_sync.sv
// Two-flop level synchroniser into the reference clock domain
`timescale 1ns/1ns
`default_nettype none
module acs_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import acs_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } acs_sync_s;

  acs_sync_s st_r;
  acs_sync_s st_nxt;

  generate
    if (W < 1) begin : g_bad_w
      $error("acs_sync width must be at least one");
    end
  endgenerate

  // First stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule
`default_nettype wire

// ### rtl/acs_link.sv
// Serial link side: command byte decode and shift-out, clocked by the host serial clock
`timescale 1ns/1ns
`default_nettype none
module acs_link (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [31:0] snap_word,
  input wire logic snap_append,
  output logic reading,
  output logic tx_bit,
  output logic stat_rd_lvl,
  output logic data_rd_lvl
);
  import acs_pkg::*;

  typedef struct packed {
    acs_phase_e phase;
    logic [5:0] cnt;
    logic [5:0] len;
    logic [31:0] sh;
    logic reading;
    logic stat_lvl;
    logic data_lvl;
  } acs_link_s;

  localparam acs_link_s LINK_RST = '{ACS_PH_CMD, 6'h00, 6'h00, 32'h00000000, 1'b0, 1'b0, 1'b0};

  acs_link_s st_r;
  acs_link_s st_nxt;
  logic [7:0] cmd;

  // Data changes just after a rising edge and holds until the next one
  always_comb begin
    st_nxt = st_r;
    cmd = {st_r.sh[6:0], sdi};
    case (st_r.phase)
      ACS_PH_CMD: begin
        st_nxt.sh = {st_r.sh[30:0], sdi};
        st_nxt.cnt = st_r.cnt + 6'h01;
        if (st_r.cnt == 6'(ACS_CMD_BITS - 1)) begin
          st_nxt.cnt = 6'h00;
          st_nxt.phase = ACS_PH_DONE;
          if (!cmd[ACS_CMD_WEN_BIT] && cmd[ACS_CMD_RW_BIT]) begin
            if (cmd[5:0] == ACS_STATUS_IDX) begin
              st_nxt.sh = {snap_word[7:0], 24'h000000};
              st_nxt.len = ACS_LEN_STATUS;
              st_nxt.stat_lvl = 1'b1;
              st_nxt.reading = 1'b1;
              st_nxt.phase = ACS_PH_SHIFT;
            end else if (cmd[5:0] == ACS_DATA_IDX) begin
              st_nxt.sh = snap_word;
              st_nxt.len = snap_append ? ACS_LEN_DATA_APP : ACS_LEN_DATA;
              st_nxt.data_lvl = 1'b1;
              st_nxt.reading = 1'b1;
              st_nxt.phase = ACS_PH_SHIFT;
            end
          end
        end
      end
      ACS_PH_SHIFT: begin
        st_nxt.sh = {st_r.sh[30:0], 1'b0};
        st_nxt.cnt = st_r.cnt + 6'h01;
        if (st_r.cnt == st_r.len - 6'h01) begin
          st_nxt.reading = 1'b0;
          st_nxt.phase = ACS_PH_DONE;
        end
      end
      ACS_PH_DONE: begin
        st_nxt.cnt = st_r.cnt;
      end
      default: begin
        st_nxt = LINK_RST;
      end
    endcase
  end

  // Frame state ends with chip select, since the serial clock stops between frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      st_r <= LINK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reading = st_r.reading;
  assign tx_bit = st_r.sh[31];
  assign stat_rd_lvl = st_r.stat_lvl;
  assign data_rd_lvl = st_r.data_lvl;
endmodule
`default_nettype wire

// ### tb/acs_host.sv
// Host model driving the serial link and capturing what the device shifts out
`timescale 1ns/1ns
`default_nettype none
module acs_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // Link clock stands high outside frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b1;
  end
  // One frame: command byte MSB first, then len bits taken at rising edges
  task automatic xfer(input logic [7:0] cmd, input int len, output logic [31:0] word);
    word = 32'h0;
    #7 cs_n = 1'b0;  // Odd offset keeps the chip select edge off the core clock phase
    #100;  // Core needs a few cycles to freeze its snapshot
    for (int i = 0; i < 8 + len; i++) begin
      sclk = 1'b0;
      sdi = (i < 8) ? cmd[7 - i] : ~sdi;
      #32;
      if (i >= 8) word = {word[30:0], sdo};
      sclk = 1'b1;
      #32;
    end
    cs_n = 1'b1;
    #120;  // Frames stay well over three core cycles apart
  endtask
endmodule
`default_nettype wire

// ### tb/acs_chk.sv
// Checker for the converter status register ports
`timescale 1ns/1ns
`default_nettype none
module acs_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sdo_oe,
  input wire logic result_wr,
  input wire logic [23:0] result_raw,
  input wire logic result_over,
  input wire logic result_under,
  input wire logic [1:0] result_chan,
  input wire logic cal_done,
  input wire logic mode_wr,
  input wire logic crc_wr_err,
  input wire logic reg_check_en,
  input wire logic [7:0] status,
  input wire logic [23:0] result_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Flag and pin relations, each but the reserved-bit check tied to the input that governs it
  rsv_zero_a: assert property (status[3:2] == 2'h0) else $error("reserved set");
  rdy_new_a: assert property (result_wr |=>
    !status[7] && status[1:0] == $past(result_chan)) else $error("result flags");
  rdy_cal_a: assert property (cal_done |=> !status[7]) else $error("cal ready");
  rdy_mode_a: assert property (mode_wr && !result_wr && !cal_done |=> status[7])
    else $error("mode ready");
  clamp_hi_a: assert property (result_wr && result_over |=>
    status[6] && result_data == 24'hffffff) else $error("clamp high");
  clamp_lo_a: assert property (result_wr && !result_over && result_under |=>
    status[6] && result_data == 24'h000000) else $error("clamp low");
  range_hold_a: assert property (!result_wr |=> $stable(status[6]))
    else $error("range");
  clean_res_a: assert property (result_wr && !result_over && !result_under |=>
    !status[6] && result_data == $past(result_raw)) else $error("clean result");
  crc_set_a: assert property (crc_wr_err |=> status[5]) else $error("crc flag");
  integ_off_a: assert property (!reg_check_en |=> !status[4]) else $error("integ");
  oe_idle_a: assert property (cs_n [*4] |-> !sdo_oe) else $error("pin driven idle");
  // Main scenarios reached
  cover property (result_wr && result_over);
  cover property ($fell(cs_n));
  cover property (crc_wr_err);
endmodule
bind acs_status acs_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sdo_oe(sdo_oe),
  .result_wr(result_wr), .result_raw(result_raw), .result_over(result_over),
  .result_under(result_under), .result_chan(result_chan), .cal_done(cal_done),
  .mode_wr(mode_wr), .crc_wr_err(crc_wr_err), .reg_check_en(reg_check_en),
  .status(status), .result_data(result_data));
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the converter status register
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import acs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe;
  logic sdo_pin;
  logic result_wr = 1'b0, result_over = 1'b0, result_under = 1'b0, cal_done = 1'b0;
  logic mode_wr = 1'b0, crc_wr_err = 1'b0, data_stat_en = 1'b0, reg_check_en = 1'b0;
  logic [23:0] result_raw = 24'h0;
  logic [1:0] result_chan = 2'h0;
  logic [15:0] reg_sum = 16'h0;
  logic [7:0] status;
  logic [23:0] result_data;
  logic [31:0] word;
  int miscompares = 0;
  int samples_checked = 0;
  // Core clock, 20 ns
  always #10 ref_clk = ~ref_clk;
  acs_status dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .result_wr(result_wr), .result_raw(result_raw),
    .result_over(result_over), .result_under(result_under), .result_chan(result_chan),
    .cal_done(cal_done), .mode_wr(mode_wr), .crc_wr_err(crc_wr_err),
    .data_stat_en(data_stat_en), .reg_check_en(reg_check_en), .reg_sum(reg_sum),
    .status(status), .result_data(result_data));
  // Undriven pin shows the inverse, so a late output enable spoils the word read
  assign sdo_pin = sdo_oe ? sdo : ~sdo;
  acs_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_pin));
  // Four-state compare so an unknown never passes
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Pulse result, cal, mode, crc events for one taken edge; look after the answer edge
  task automatic ev(input logic [3:0] w);
    @(posedge ref_clk);
    {result_wr, cal_done, mode_wr, crc_wr_err} <= w;
    @(posedge ref_clk);
    {result_wr, cal_done, mode_wr, crc_wr_err} <= 4'h0;
    #1;
  endtask
  // Channels 0..3: a clean result, an overrange, an underrange, then a clean result
  task automatic t_result();
    for (int c = 0; c < 4; c++) begin
      @(posedge ref_clk);
      result_raw <= 24'h5a5a5a + 24'(c);
      result_chan <= 2'(c);
      result_over <= (c == 1);
      result_under <= (c == 2);
      ev(4'h8);
      chk("data", (c == 1) ? 32'hffffff : (c == 2) ? 32'h0 : 32'h5a5a5a + c,
        {8'h0, result_data});
      // Range flag sits in bit 6, channel in bits 1:0
      chk("status", {24'h0, 1'b0, 1'(c == 1 || c == 2), 4'h0, 2'(c)},
        {24'h0, status});
    end
  endtask
  // Write-check fault shows in a status read, then the read clears it
  task automatic t_stat_read();
    ev(4'h1);
    chk("status", 32'h23, {24'h0, status});
    host.xfer(8'h40, 8, word);
    chk("read", 32'h23, word);
    chk("status", 32'h03, {24'h0, status});
  endtask
  // Data read with status appended sets ready again
  task automatic t_data_read();
    @(posedge ref_clk);
    data_stat_en <= 1'b1;
    host.xfer(8'h44, 32, word);
    chk("read", {24'h5a5a5d, 8'h03}, word);
    chk("status", 32'h83, {24'h0, status});
  endtask
  // Refused frames leave the pin showing the ready flag, set before a result and clear after it; a write does not touch status
  task automatic t_pin();
    host.xfer(8'hc0, 8, word);
    chk("pin", 32'hff, word);
    ev(4'h8);
    host.xfer(8'h00, 8, word);
    chk("pin", 32'h00, word);
    chk("status", 32'h03, {24'h0, status});
    // Chip select has been high for six core cycles, so the pin is released
    chk("oe", 32'h0, {31'h0, sdo_oe});
  endtask
  // Mode write raises ready, stored calibration drops it
  task automatic t_cal_mode();
    ev(4'h2);
    chk("ready", 32'h1, {31'h0, status[7]});
    ev(4'h4);
    chk("ready", 32'h0, {31'h0, status[7]});
  endtask
  // Integrity fault on a checksum change, cleared only by disabling the check
  task automatic t_integ();
    @(posedge ref_clk);
    reg_sum <= 16'h1234;
    reg_check_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reg_sum <= 16'h4321;
    repeat (2) @(posedge ref_clk);
    #1 chk("integ", 32'h1, {31'h0, status[4]});
    @(posedge ref_clk);
    reg_check_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("integ", 32'h0, {31'h0, status[4]});
  endtask
  // Reset, then the scenarios in order; state carries from one to the next
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk("reset", 32'h80, {24'h0, status});
    chk("reset", 32'h0, {8'h0, result_data});
    repeat (3) @(posedge ref_clk);
    t_result();
    t_stat_read();
    t_data_read();
    t_pin();
    t_cal_mode();
    t_integ();
    give_verdict();
  end
  // Watchdog, far beyond the few microseconds the frames take
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
